//--- core/regulator_status_readback.sv
// regulator_status_readback: status bank of two step-down and two linear regulators,
// top-level event mask, latched top-level event flags and the masked event request.
// assumes: raw regulator levels are synchronous to sys_clk; register port is a simple
// synchronous read/write strobe port driven by the serial control logic.
// How it works
// - bit7 step-down status: regulator 1 enabled
// - bit6 step-down status: regulator 1 voltage bad
// - bit4 step-down status: regulator 1 limiting
// - bit3 step-down status: regulator 0 enabled
// - bit2 step-down status: regulator 0 voltage bad
// - bit0 step-down status: regulator 0 limiting
// - bit7 linear status: regulator 1 enabled
// - bit6 linear status: regulator 1 voltage bad
// - bit4 linear status: regulator 1 limiting
// - bit3 linear status: regulator 0 enabled
// - bit2 linear status: regulator 0 voltage bad
// - bit0 linear status: regulator 0 limiting
// - mask bit 1 suppresses the request; flag still latches, status untouched
// - event flags latch; write 1 clears
`timescale 1ns/1ps
`default_nettype none

module regulator_status_readback #(
    parameter int EVENT_W = regstat_pkg::EVENT_W
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    // register port
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    output logic                        reg_rvalid,
    // raw regulator levels
    input  wire logic                   stepdown1_on,
    input  wire logic                   stepdown1_vout_bad,
    input  wire logic                   stepdown1_limiting,
    input  wire logic                   stepdown0_on,
    input  wire logic                   stepdown0_vout_bad,
    input  wire logic                   stepdown0_limiting,
    input  wire logic                   linreg1_on,
    input  wire logic                   linreg1_vout_bad,
    input  wire logic                   linreg1_limiting,
    input  wire logic                   linreg0_on,
    input  wire logic                   linreg0_vout_bad,
    input  wire logic                   linreg0_limiting,
    // top-level events: pgood, extclk, thermal, load measurement ready
    input  wire logic [EVENT_W-1:0]     top_event_pulse,
    input  wire logic                   event_flag_clear_wr,
    input  wire logic [EVENT_W-1:0]     event_flag_clear,
    output logic      [EVENT_W-1:0]     event_flags,
    output logic                        event_irq,
    output logic      [7:0]             top_event_mask
);

    // elaboration check: the mask mapping below serves exactly four events,
    // so any other width is refused before anything runs
    if (EVENT_W != regstat_pkg::EVENT_W) begin : g_bad_event_w
        $error("EVENT_W must be 4");
    end

    // packs one regulator pair into the shared status layout, reserved bits zero
    function automatic logic [7:0] pack_status(
        input logic on1, input logic bad1, input logic lim1,
        input logic on0, input logic bad0, input logic lim0);
        logic [7:0] v;
        v = regstat_pkg::STATUS_RESET;
        v[regstat_pkg::BIT_REG1_ON]    = on1;
        v[regstat_pkg::BIT_REG1_VBAD]  = bad1;
        v[regstat_pkg::BIT_REG1_LIMIT] = lim1;
        v[regstat_pkg::BIT_REG0_ON]    = on0;
        v[regstat_pkg::BIT_REG0_VBAD]  = bad0;
        v[regstat_pkg::BIT_REG0_LIMIT] = lim0;
        return v;
    endfunction : pack_status

    logic [7:0]         stepdown_status;
    logic [7:0]         linreg_status;
    logic [EVENT_W-1:0] mask_vec;
    logic [7:0]         next_rdata;
    logic               mask_hit;
    logic [EVENT_W-1:0] next_flags;
    logic               next_irq;

    assign stepdown_status = pack_status(stepdown1_on, stepdown1_vout_bad, stepdown1_limiting,
                                         stepdown0_on, stepdown0_vout_bad, stepdown0_limiting);
    assign linreg_status = pack_status(linreg1_on, linreg1_vout_bad, linreg1_limiting,
                                       linreg0_on, linreg0_vout_bad, linreg0_limiting);

    assign mask_vec = {top_event_mask[regstat_pkg::BIT_MASK_LOADMEAS],
                       top_event_mask[regstat_pkg::BIT_MASK_THERMAL],
                       top_event_mask[regstat_pkg::BIT_MASK_EXTCLK],
                       top_event_mask[regstat_pkg::BIT_MASK_PGOOD]};
    assign mask_hit = reg_wr && (reg_addr == regstat_pkg::TOP_EVENT_MASK);

    // read decode; status registers reflect raw levels, never latched
    always_comb begin
        case (reg_addr)
            regstat_pkg::STEPDOWN_STATUS: next_rdata = stepdown_status;
            regstat_pkg::LINREG_STATUS:   next_rdata = linreg_status;
            regstat_pkg::TOP_EVENT_MASK:  next_rdata = top_event_mask;
            default:                      next_rdata = regstat_pkg::UNMAPPED_READ;
        endcase
    end

    assign next_flags = (event_flags & ~(event_flag_clear_wr ? event_flag_clear
                                                             : regstat_pkg::EVENTS_NONE))
                        | top_event_pulse;
    assign next_irq = |(next_flags & ~mask_vec);

    // read data registered one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= regstat_pkg::UNMAPPED_READ;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            top_event_mask <= regstat_pkg::MASK_RESET;
        else if (clk_en && mask_hit)
            top_event_mask <= reg_wdata & regstat_pkg::MASK_WRITABLE;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            event_flags <= regstat_pkg::EVENTS_NONE;
            event_irq   <= 1'b0;
        end else if (clk_en) begin
            event_flags <= next_flags;
            event_irq   <= next_irq;
        end
    end

    AST_SD1_ON: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_rd && reg_addr == regstat_pkg::STEPDOWN_STATUS)
        |=> reg_rdata[7] == $past(stepdown1_on))
        else $error("stepdown1 enable bit wrong");
    AST_SD1_VBAD: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_rd && reg_addr == regstat_pkg::STEPDOWN_STATUS)
        |=> reg_rdata[6] == $past(stepdown1_vout_bad))
        else $error("stepdown1 voltage bit wrong");
    AST_SD1_LIM: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_rd && reg_addr == regstat_pkg::STEPDOWN_STATUS)
        |=> reg_rdata[4] == $past(stepdown1_limiting))
        else $error("stepdown1 limit bit wrong");
    AST_SD0: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_rd && reg_addr == regstat_pkg::STEPDOWN_STATUS)
        |=> reg_rdata[3:2] == {$past(stepdown0_on), $past(stepdown0_vout_bad)})
        else $error("stepdown0 enable or voltage bit wrong");
    AST_SD0_LIM: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_rd && reg_addr == regstat_pkg::STEPDOWN_STATUS)
        |=> reg_rdata[0] == $past(stepdown0_limiting))
        else $error("stepdown0 limit bit wrong");
    AST_LR1: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_rd && reg_addr == regstat_pkg::LINREG_STATUS)
        |=> reg_rdata[7:6] == {$past(linreg1_on), $past(linreg1_vout_bad)}
            && reg_rdata[4] == $past(linreg1_limiting))
        else $error("linreg1 fields wrong");
    AST_LR0: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_rd && reg_addr == regstat_pkg::LINREG_STATUS)
        |=> reg_rdata[3:2] == {$past(linreg0_on), $past(linreg0_vout_bad)}
            && reg_rdata[0] == $past(linreg0_limiting))
        else $error("linreg0 fields wrong");
    AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_rd && (reg_addr == regstat_pkg::STEPDOWN_STATUS
                              || reg_addr == regstat_pkg::LINREG_STATUS))
        |=> reg_rdata[5] == 1'b0 && reg_rdata[1] == 1'b0)
        else $error("reserved status bit set");
    AST_MASK_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && mask_hit)
        |=> top_event_mask == ($past(reg_wdata) & regstat_pkg::MASK_WRITABLE))
        else $error("mask write wrong");

    sequence s_event_in;
        clk_en && top_event_pulse[0];
    endsequence
    sequence s_flag_held;
        event_flags[0] ##1 (event_flags[0] || $past(event_flag_clear_wr && event_flag_clear[0]));
    endsequence
    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst)
        s_event_in |=> s_flag_held)
        else $error("event lost on clear");
    AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && event_flag_clear_wr && event_flag_clear[1] && !top_event_pulse[1])
        |=> !event_flags[1])
        else $error("flag not cleared by write one");
    AST_MASK_GATES: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && (next_flags & ~mask_vec) == regstat_pkg::EVENTS_NONE) |=> !event_irq)
        else $error("masked event raised request");
    AST_UNMASKED: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && top_event_pulse[0] && !mask_vec[0]) |=> event_irq)
        else $error("unmasked event gave no request");

    // register port steps shared by the read and write checks below
    sequence s_rd_taken;
        clk_en && reg_rd;
    endsequence
    sequence s_idle_taken;
        clk_en && !reg_rd;
    endsequence
    sequence s_unmapped_rd;
        clk_en && reg_rd
            && reg_addr != regstat_pkg::STEPDOWN_STATUS
            && reg_addr != regstat_pkg::LINREG_STATUS
            && reg_addr != regstat_pkg::TOP_EVENT_MASK;
    endsequence
    sequence s_mask_rd;
        clk_en && reg_rd && reg_addr == regstat_pkg::TOP_EVENT_MASK;
    endsequence
    sequence s_status_wr;
        clk_en && reg_wr && (reg_addr == regstat_pkg::STEPDOWN_STATUS
                             || reg_addr == regstat_pkg::LINREG_STATUS);
    endsequence
    sequence s_no_mask_wr;
        clk_en && !mask_hit;
    endsequence
    sequence s_frozen;
        !clk_en;
    endsequence

    AST_RVALID_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
        s_rd_taken |=> reg_rvalid)
        else $error("read gave no valid pulse");
    AST_RVALID_DROP: assert property (@(posedge sys_clk) disable iff (rst)
        s_idle_taken |=> !reg_rvalid)
        else $error("valid pulse held too long");
    // read data holds until next read
    AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        s_idle_taken |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        s_unmapped_rd |=> reg_rdata == regstat_pkg::UNMAPPED_READ)
        else $error("unmapped read not zero");
    AST_MASK_READBACK: assert property (@(posedge sys_clk) disable iff (rst)
        s_mask_rd |=> reg_rdata == $past(top_event_mask))
        else $error("mask read back wrong");
    AST_STATUS_WR_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
        s_status_wr |=> $stable(top_event_mask))
        else $error("status write changed state");
    // mask changes only on its write
    AST_MASK_KEEP: assert property (@(posedge sys_clk) disable iff (rst)
        s_no_mask_wr |=> $stable(top_event_mask))
        else $error("mask changed without a write");
    AST_FREEZE: assert property (@(posedge sys_clk) disable iff (rst)
        s_frozen |=> $stable(event_flags) && $stable(event_irq)
                     && $stable(top_event_mask) && $stable(reg_rdata)
                     && $stable(reg_rvalid))
        else $error("state moved while enable low");
    // request only with some flag set
    AST_IRQ_NEEDS_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
        event_irq |-> (event_flags != regstat_pkg::EVENTS_NONE))
        else $error("request without any flag");

    // per-event checks; each flag is its own latch, so each gets its own copy
    for (genvar k = 0; k < EVENT_W; k++) begin : g_event_checks
        AST_EVENT_SETS: assert property (@(posedge sys_clk) disable iff (rst)
            (clk_en && top_event_pulse[k]) |=> event_flags[k])
            else $error("event pulse did not set its flag");
        AST_FLAG_KEEP: assert property (@(posedge sys_clk) disable iff (rst)
            (clk_en && event_flags[k] && !(event_flag_clear_wr && event_flag_clear[k]))
            |=> event_flags[k])
            else $error("flag lost without a clear");
        AST_UNMASKED_ALL: assert property (@(posedge sys_clk) disable iff (rst)
            (clk_en && top_event_pulse[k] && !mask_vec[k]) |=> event_irq)
            else $error("unmasked event gave no request");
    end

endmodule : regulator_status_readback
`default_nettype wire

//--- core/regstat_pkg.sv
// regstat_pkg: offsets, field positions and reset values for the regulator status bank
// assumes: 8-bit register port with 8-bit addresses inside the power-management device
package regstat_pkg;
    localparam int          DATA_W            = 8;
    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  STEPDOWN_STATUS   = 8'h1E;
    localparam logic [7:0]  LINREG_STATUS     = 8'h1F;
    localparam logic [7:0]  TOP_EVENT_MASK    = 8'h20;
    // field positions shared by both status registers
    localparam int          BIT_REG1_ON       = 7;
    localparam int          BIT_REG1_VBAD     = 6;
    localparam int          BIT_REG1_LIMIT    = 4;
    localparam int          BIT_REG0_ON       = 3;
    localparam int          BIT_REG0_VBAD     = 2;
    localparam int          BIT_REG0_LIMIT    = 0;
    // top-level mask fields
    localparam int          BIT_MASK_PGOOD    = 7;
    localparam int          BIT_MASK_EXTCLK   = 4;
    localparam int          BIT_MASK_THERMAL  = 2;
    localparam int          BIT_MASK_LOADMEAS = 0;
    localparam logic [7:0]  MASK_WRITABLE     = 8'h95;
    localparam logic [7:0]  MASK_RESET        = 8'h00;
    localparam logic [7:0]  STATUS_RESET      = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ     = 8'h00;
    localparam int          EVENT_W           = 4;
    localparam logic [3:0]  EVENTS_NONE       = 4'h0;
endpackage : regstat_pkg

//--- dv/tb_top.sv
// tb_top: self-checking bench for the regulator status bank
// assumes: one 200 MHz clock, inputs driven 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        sys_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic        clk_en    = 1'b1;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [11:0] raw       = 12'h000;
    logic [3:0]  pulse     = 4'h0;
    logic        clr_wr    = 1'b0;
    logic [3:0]  clr       = 4'h0;
    logic [7:0]  reg_rdata;
    logic [7:0]  top_event_mask;
    logic        reg_rvalid;
    logic        event_irq;
    logic [3:0]  event_flags;
    int          n_errors    = 0;
    int          check_count = 0;
    int          cycles      = 0;
    int          mpos [4]    = '{7, 4, 2, 0};

    // clock: half period 2.5 ns
    always #2.5 sys_clk = ~sys_clk;

    // raw levels: [11:6] step-down, [5:0] linear, each {1on,1bad,1lim,0on,0bad,0lim}
    regulator_status_readback u_regulator_status_readback (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .stepdown1_on(raw[11]), .stepdown1_vout_bad(raw[10]), .stepdown1_limiting(raw[9]),
        .stepdown0_on(raw[8]), .stepdown0_vout_bad(raw[7]), .stepdown0_limiting(raw[6]),
        .linreg1_on(raw[5]), .linreg1_vout_bad(raw[4]), .linreg1_limiting(raw[3]),
        .linreg0_on(raw[2]), .linreg0_vout_bad(raw[1]), .linreg0_limiting(raw[0]),
        .top_event_pulse(pulse), .event_flag_clear_wr(clr_wr), .event_flag_clear(clr),
        .event_flags(event_flags), .event_irq(event_irq), .top_event_mask(top_event_mask));

    // expected status byte; reserved bits 5 and 1 always zero
    function automatic logic [7:0] stat(input logic [5:0] v);
        return {v[5], v[4], 1'b0, v[3], v[2], v[1], 1'b0, v[0]};
    endfunction : stat

    task automatic end_of_test;
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write strobe; released one edge later so calls never overlap
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
    endtask : wr_reg

    // read answer lands on the same edge that takes the strobe and is checked 1 ns later
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask : rd_chk

    // one cycle of event pulses and flag clearing
    task automatic drv(input logic [3:0] p, input logic w, input logic [3:0] c);
        @(posedge sys_clk);
        #1 pulse = p;
        clr_wr = w;
        clr = c;
        @(posedge sys_clk);
        #1 pulse = 4'h0;
        clr_wr = 1'b0;
    endtask : drv

    // hang guard, far above the 150-odd cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end

    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        chk({4'h0, event_flags}, 8'h00);
        rd_chk(regstat_pkg::TOP_EVENT_MASK, 8'h00);
        rd_chk(8'h55, 8'h00);
        for (int i = 0; i < 12; i++) begin
            raw = 12'h001 << i;
            rd_chk(regstat_pkg::STEPDOWN_STATUS, stat(raw[11:6]));
            rd_chk(regstat_pkg::LINREG_STATUS, stat(raw[5:0]));
        end
        // writes of the inverse must not stick in either status byte
        for (int k = 0; k < 2; k++) begin
            raw = (k == 1) ? 12'hFFF : 12'h000;
            wr_reg(regstat_pkg::STEPDOWN_STATUS, ~raw[7:0]);
            wr_reg(regstat_pkg::LINREG_STATUS, ~raw[7:0]);
            rd_chk(regstat_pkg::STEPDOWN_STATUS, (k == 1) ? 8'hDD : 8'h00);
            rd_chk(regstat_pkg::LINREG_STATUS, (k == 1) ? 8'hDD : 8'h00);
        end
        wr_reg(regstat_pkg::TOP_EVENT_MASK, 8'hFF);
        rd_chk(regstat_pkg::TOP_EVENT_MASK, 8'h95);
        chk(top_event_mask, 8'h95);
        wr_reg(regstat_pkg::TOP_EVENT_MASK, 8'h6A);
        rd_chk(regstat_pkg::TOP_EVENT_MASK, 8'h00);
        // each event unmasked, cleared, then masked
        for (int e = 0; e < 4; e++) begin
            wr_reg(regstat_pkg::TOP_EVENT_MASK, 8'h00);
            drv(4'h1 << e, 1'b0, 4'h0);
            chk({4'h0, event_flags}, 8'h01 << e);
            chk({7'h00, event_irq}, 8'h01);
            drv(4'h0, 1'b1, ~(4'h1 << e));
            chk({4'h0, event_flags}, 8'h01 << e);
            drv(4'h0, 1'b1, 4'h1 << e);
            chk({4'h0, event_flags}, 8'h00);
            chk({7'h00, event_irq}, 8'h00);
            wr_reg(regstat_pkg::TOP_EVENT_MASK, 8'h01 << mpos[e]);
            drv(4'h1 << e, 1'b0, 4'h0);
            chk({4'h0, event_flags}, 8'h01 << e);
            chk({7'h00, event_irq}, 8'h00);
            rd_chk(regstat_pkg::STEPDOWN_STATUS, 8'hDD);
            drv(4'h0, 1'b1, 4'h1 << e);
        end
        // low enable: pulse and mask write in that cycle are both lost
        @(posedge sys_clk);
        #1 clk_en = 1'b0;
        pulse = 4'h1;
        reg_wr = 1'b1;
        reg_addr = regstat_pkg::TOP_EVENT_MASK;
        reg_wdata = 8'hFF;
        @(posedge sys_clk);
        #1 clk_en = 1'b1;
        pulse = 4'h0;
        reg_wr = 1'b0;
        chk({4'h0, event_flags}, 8'h00);
        chk(top_event_mask, 8'h01);
        // mid-run reset wipes a pending flag, its request and the mask
        drv(4'h2, 1'b0, 4'h0);
        chk({7'h00, event_irq}, 8'h01);
        rst = 1'b1;
        @(posedge sys_clk);
        #1 rst = 1'b0;
        chk({4'h0, event_flags}, 8'h00);
        chk({7'h00, event_irq}, 8'h00);
        rd_chk(regstat_pkg::TOP_EVENT_MASK, 8'h00);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
